// >>> rtl/jril_loader.sv
// Function
// - Loads RAM contents from JTAG path
// - Takes command, serial data, bridge clock
// - Synchronizes words, writes correct RAM block
// - One chip select per block
// - Drives write address per word
// - Serial bits presented as parallel data
// - Drives aligned RAM write clock
// - Shift register as wide as RAM
// - Bits shift on bridge data clock
// - Transfer only complete words
// - Pipeline stage before RAM
// - Address shifted in or counted
module jril_loader (
    input  wire logic                       clock_in,
    input  wire logic                       sys_rst_in,
    input  wire logic                       bridge_data_reg_clock_in,
    input  wire logic [jril_pkg::CMD_W-1:0] bridge_command_in,
    input  wire logic                       bridge_serial_data_out_in,
    output logic [jril_pkg::NUM_BLK-1:0]    ram_cs_out,
    output logic [jril_pkg::ADDR_W-1:0]     ram_waddr_out,
    output logic [jril_pkg::DATA_W-1:0]     ram_wdata_out,
    output logic                            ram_wclk_out,
    output logic                            loading_out,
    output logic                            overrun_out
);

    // ==========================================================
    // State
    typedef struct packed {
        logic                          tog_meta;
        logic                          tog_sync;
        logic                          tog_seen;
        logic                          act_meta;
        logic                          act_sync;
        logic                          act_seen;
        logic                          pending;
        jril_pkg::jril_entry_t         pend;
        logic                          overrun;
        jril_pkg::jril_state_t         state;
        jril_pkg::jril_entry_t         entry;
        logic [jril_pkg::NUM_BLK-1:0]  ring;
        jril_pkg::jril_ram_port_t      ram;
    } jril_loader_state_t;

    jril_loader_state_t    s_reg;
    jril_loader_state_t    s_next;
    jril_pkg::jril_entry_t link_hold;
    logic                  link_toggle;
    logic                  link_active;
    logic                  push_ready;
    logic                  pop_valid;
    logic                  pop_ready;
    jril_pkg::jril_entry_t pop_data;
    logic                  word_evt;
    logic                  session_start;

    function automatic logic [jril_pkg::NUM_BLK-1:0] rotate(
        input logic [jril_pkg::NUM_BLK-1:0] r
    );
        rotate = {r[jril_pkg::NUM_BLK-2:0], r[jril_pkg::NUM_BLK-1]};
    endfunction

    // ==========================================================
    // Link side
    // JTAG-fed load path
    jril_link u_link (
        .link_clk_in (bridge_data_reg_clock_in),
        .sys_rst_in  (sys_rst_in),
        .cmd_in      (bridge_command_in),
        .serial_in   (bridge_serial_data_out_in),
        .hold_out    (link_hold),
        .toggle_out  (link_toggle),
        .active_out  (link_active)
    );

    // ==========================================================
    // Word buffer
    jril_fifo #(
        .WIDTH (jril_pkg::ENTRY_W),
        .DEPTH (jril_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock_in       (clock_in),
        .sys_rst_in     (sys_rst_in),
        .push_valid_in  (s_reg.pending),
        .push_ready_out (push_ready),
        .push_data_in   (s_reg.pend),
        .pop_valid_out  (pop_valid),
        .pop_ready_in   (pop_ready),
        .pop_data_out   (pop_data)
    );

    // Toggle crossing; hold word is stable for a whole word time
    assign word_evt  = s_reg.tog_sync ^ s_reg.tog_seen;
    // Drain only while a load command is active
    assign pop_ready = (s_reg.state == jril_pkg::ST_IDLE) && s_reg.act_sync;
    // Rising load flag opens a session
    assign session_start = s_reg.act_sync && !s_reg.act_seen;

    // ==========================================================
    // Next state
    always_comb begin
        s_next          = s_reg;
        s_next.tog_meta = link_toggle;
        s_next.tog_sync = s_reg.tog_meta;
        s_next.tog_seen = s_reg.tog_sync;
        s_next.act_meta = link_active;
        s_next.act_sync = s_reg.act_meta;
        s_next.act_seen = s_reg.act_sync;

        if (s_reg.pending && push_ready) begin
            s_next.pending = 1'b0;
        end
        // Stalled buffer loses the word; flag it rather than hide it
        if (word_evt) begin
            if (s_reg.pending && !push_ready) begin
                s_next.overrun = 1'b1;
            end else begin
                s_next.pending = 1'b1;
                s_next.pend    = link_hold;
            end
        end

        unique case (s_reg.state)
            jril_pkg::ST_IDLE: begin
                // One word in flight keeps address, data, select aligned
                if (pop_valid && pop_ready) begin
                    s_next.entry = pop_data;
                    s_next.state = jril_pkg::ST_SETUP;
                end
            end
            jril_pkg::ST_SETUP: begin
                if (s_reg.entry.is_addr) begin
                    s_next.ram.addr = s_reg.entry.payload[jril_pkg::ADDR_W-1:0];
                    s_next.state    = jril_pkg::ST_IDLE;
                end else begin
                    s_next.ram.data = s_reg.entry.payload[jril_pkg::DATA_W-1:0];
                    s_next.ram.cs   = s_reg.ring;
                    s_next.state    = jril_pkg::ST_STROBE;
                end
            end
            jril_pkg::ST_STROBE: begin
                // Clock edge after data, address, select settle
                s_next.ram.wclk = 1'b1;
                s_next.state    = jril_pkg::ST_ADVANCE;
            end
            jril_pkg::ST_ADVANCE: begin
                // Select drops with the clock: no block sees a stray edge
                s_next.ram.wclk = 1'b0;
                s_next.ram.cs   = '0;
                if (s_reg.ram.addr == jril_pkg::ADDR_LAST) begin
                    s_next.ram.addr = jril_pkg::ADDR_RESET;
                    s_next.ring     = rotate(s_reg.ring);
                end else begin
                    s_next.ram.addr = s_reg.ram.addr + 1'b1;
                end
                s_next.state = jril_pkg::ST_IDLE;
            end
        endcase

        // New load session restarts the sweep at block 0
        if (session_start) begin
            s_next.ring     = jril_pkg::RING_RESET;
            s_next.ram.addr = jril_pkg::ADDR_RESET;
            // A word dropped in this very cycle still flags
            s_next.overrun  = word_evt && s_reg.pending && !push_ready;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            s_reg      <= '0;
            // Ring starts one-hot so ring_one_hot_a holds from reset; each session start reloads RING_RESET as well
            s_reg.ring <= jril_pkg::RING_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign ram_cs_out    = s_reg.ram.cs;
    assign ram_waddr_out = s_reg.ram.addr;
    assign ram_wdata_out = s_reg.ram.data;
    assign ram_wclk_out  = s_reg.ram.wclk;
    assign loading_out   = s_reg.act_sync;
    assign overrun_out   = s_reg.overrun;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (sys_rst_in);

    wclk_pulse_width_a: assert property (
        $rose(ram_wclk_out) |=> !ram_wclk_out
    ) else $error("write clock high longer than one cycle");

    cs_one_hot_a: assert property (
        ram_wclk_out |-> $onehot(ram_cs_out)
    ) else $error("write clock without exactly one select");

    wdata_setup_hold_a: assert property (
        $rose(ram_wclk_out) |-> $stable(ram_wdata_out) && $stable(ram_waddr_out)
    ) else $error("write data or address moved at write edge");

    data_to_write_a: assert property (
        (pop_valid && pop_ready && !pop_data.is_addr) |-> ##3 $rose(ram_wclk_out)
    ) else $error("data word not written three cycles after pop");

    addr_word_nowrite_a: assert property (
        (pop_valid && pop_ready && pop_data.is_addr)
            |-> ##2 (ram_waddr_out == $past(pop_data.payload[jril_pkg::ADDR_W-1:0], 2))
            ##1 ($stable(ram_waddr_out) && !ram_wclk_out)
    ) else $error("address word did not load address counter");

    addr_step_a: assert property (
        (s_reg.state == jril_pkg::ST_ADVANCE && ram_waddr_out != jril_pkg::ADDR_LAST
            && !(s_reg.act_sync && !s_reg.act_seen))
            |=> ram_waddr_out == $past(ram_waddr_out) + 1'b1
    ) else $error("address did not step after write");

    block_rotate_a: assert property (
        (s_reg.state == jril_pkg::ST_ADVANCE && ram_waddr_out == jril_pkg::ADDR_LAST
            && !(s_reg.act_sync && !s_reg.act_seen))
            |=> s_reg.ring == rotate($past(s_reg.ring)) && ram_waddr_out == '0
    ) else $error("block select did not move on address wrap");

    idle_no_write_a: assert property (
        (!loading_out && s_reg.state == jril_pkg::ST_IDLE) |=> (!$rose(ram_wclk_out))[*3]
    ) else $error("write while no load command active");

    word_push_a: assert property (
        (word_evt && !(s_reg.pending && !push_ready)) |=> s_reg.pending
            && s_reg.pend == $past(link_hold)
    ) else $error("completed word not captured for buffer");

    // ==========================================================
    // Checks on select, data and sequencing

    ring_one_hot_a: assert property (
        $onehot(s_reg.ring)
    ) else $error("block ring lost its single set bit");

    cs_idle_zero_a: assert property (
        (s_reg.state == jril_pkg::ST_IDLE || s_reg.state == jril_pkg::ST_SETUP)
            |-> ram_cs_out == '0
    ) else $error("block select active outside a write");

    wclk_fall_clear_a: assert property (
        $fell(ram_wclk_out) |-> ram_cs_out == '0
    ) else $error("select still active after write clock fell");

    wclk_in_advance_a: assert property (
        ram_wclk_out |-> s_reg.state == jril_pkg::ST_ADVANCE
    ) else $error("write clock high outside its slot");

    wdata_match_a: assert property (
        $rose(ram_wclk_out) |-> ram_wdata_out == s_reg.entry.payload[jril_pkg::DATA_W-1:0]
    ) else $error("write data differs from assembled word");

    addr_change_src_a: assert property (
        $changed(ram_waddr_out)
            |-> $past(s_reg.state) inside {jril_pkg::ST_SETUP, jril_pkg::ST_ADVANCE}
            || $past(session_start)
    ) else $error("write address moved without a cause");

    setup_to_strobe_a: assert property (
        s_reg.state == jril_pkg::ST_STROBE
            |-> $past(s_reg.state) == jril_pkg::ST_SETUP && !s_reg.entry.is_addr
    ) else $error("write strobe without a complete data word");

    rise_from_strobe_a: assert property (
        $rose(ram_wclk_out) |-> $past(s_reg.state) == jril_pkg::ST_STROBE
    ) else $error("write clock rose outside the strobe slot");

    setup_needs_load_a: assert property (
        s_reg.state == jril_pkg::ST_SETUP |-> $past(loading_out)
    ) else $error("word taken while no load command active");

    advance_to_idle_a: assert property (
        s_reg.state == jril_pkg::ST_ADVANCE |=> s_reg.state == jril_pkg::ST_IDLE
    ) else $error("sequencer did not return to idle after a write");

    session_restart_a: assert property (
        session_start
            |=> ram_waddr_out == jril_pkg::ADDR_RESET && s_reg.ring == jril_pkg::RING_RESET
    ) else $error("new load session did not restart at block 0");

    addr_word_no_cs_a: assert property (
        (s_reg.state == jril_pkg::ST_SETUP && s_reg.entry.is_addr)
            |=> ram_cs_out == '0 && !ram_wclk_out && s_reg.state == jril_pkg::ST_IDLE
    ) else $error("address word produced a write");

    pop_into_entry_a: assert property (
        (pop_valid && pop_ready)
            |=> s_reg.entry == $past(pop_data) && s_reg.state == jril_pkg::ST_SETUP
    ) else $error("popped word not held in pipeline stage");

endmodule

// >>> include/jril_pkg.sv
package jril_pkg;

    // ==========================================================
    // Sizes
    localparam int DATA_W     = 9;
    localparam int ADDR_W     = 9;
    localparam int CMD_W      = 8;
    localparam int NUM_BLK    = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int PAY_W      = (DATA_W > ADDR_W) ? DATA_W : ADDR_W;

    // ==========================================================
    // Opcodes and reset values
    localparam logic [CMD_W-1:0]   CMD_LOAD_DATA = 8'h21;
    localparam logic [CMD_W-1:0]   CMD_LOAD_ADDR = 8'h22;
    localparam logic [ADDR_W-1:0]  ADDR_LAST     = 9'h1FF;
    localparam logic [ADDR_W-1:0]  ADDR_RESET    = 9'h000;
    localparam logic [NUM_BLK-1:0] RING_RESET    = 4'h1;

    // ==========================================================
    // Types
    typedef struct packed {
        logic             is_addr;
        logic [PAY_W-1:0] payload;
    } jril_entry_t;

    localparam int ENTRY_W = $bits(jril_entry_t);

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_SETUP   = 2'b01,
        ST_STROBE  = 2'b11,
        ST_ADVANCE = 2'b10
    } jril_state_t;

    typedef struct packed {
        logic [NUM_BLK-1:0] cs;
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  data;
        logic               wclk;
    } jril_ram_port_t;

endpackage

// >>> rtl/jril_fifo.sv
module jril_fifo #(
    parameter int WIDTH = jril_pkg::ENTRY_W,
    parameter int DEPTH = jril_pkg::FIFO_DEPTH
) (
    input  wire logic             clock_in,
    input  wire logic             sys_rst_in,
    input  wire logic             push_valid_in,
    output logic                  push_ready_out,
    input  wire logic [WIDTH-1:0] push_data_in,
    output logic                  pop_valid_out,
    input  wire logic             pop_ready_in,
    output logic      [WIDTH-1:0] pop_data_out
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [CW-1:0] count;
    } jril_fifo_state_t;

    jril_fifo_state_t   s_reg;
    jril_fifo_state_t   s_next;
    logic [WIDTH-1:0]   mem [DEPTH];
    logic               do_push;
    logic               do_pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign push_ready_out = (s_reg.count != CW'(DEPTH));
    assign pop_valid_out  = (s_reg.count != '0);
    assign pop_data_out   = mem[s_reg.rp];
    assign do_push        = push_valid_in && push_ready_out;
    assign do_pop         = pop_valid_out && pop_ready_in;

    always_comb begin
        s_next = s_reg;
        if (do_push) begin
            s_next.wp = bump(s_reg.wp);
        end
        if (do_pop) begin
            s_next.rp = bump(s_reg.rp);
        end
        s_next.count = s_reg.count + CW'(do_push) - CW'(do_pop);
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Storage needs no reset; count guards reads
    always_ff @(posedge clock_in) begin
        if (do_push) begin
            mem[s_reg.wp] <= push_data_in;
        end
    end

endmodule

// >>> rtl/jril_link.sv
module jril_link (
    input  wire logic                          link_clk_in,
    input  wire logic                          sys_rst_in,
    input  wire logic [jril_pkg::CMD_W-1:0]    cmd_in,
    input  wire logic                          serial_in,
    output jril_pkg::jril_entry_t              hold_out,
    output logic                               toggle_out,
    output logic                               active_out
);
    localparam int NW = $clog2(jril_pkg::PAY_W + 1);

    typedef struct packed {
        logic                        rst_meta;
        logic                        rst_sync;
        logic [jril_pkg::PAY_W-1:0]  shift;
        logic [NW-1:0]               count;
        jril_pkg::jril_entry_t       hold;
        logic                        toggle;
        logic                        active;
    } jril_link_state_t;

    jril_link_state_t s_reg;
    jril_link_state_t s_next;

    always_comb begin
        logic                       data_mode;
        logic                       addr_mode;
        logic [NW-1:0]              width;
        logic [jril_pkg::PAY_W-1:0] nsh;
        data_mode = (cmd_in == jril_pkg::CMD_LOAD_DATA);
        addr_mode = (cmd_in == jril_pkg::CMD_LOAD_ADDR);
        width     = addr_mode ? NW'(jril_pkg::ADDR_W) : NW'(jril_pkg::DATA_W);
        nsh       = {serial_in, s_reg.shift[jril_pkg::PAY_W-1:1]};
        s_next          = s_reg;
        // Reset arrives from the system clock, so two stages first
        s_next.rst_meta = sys_rst_in;
        s_next.rst_sync = s_reg.rst_meta;
        if (s_reg.rst_sync) begin
            s_next.shift  = '0;
            s_next.count  = '0;
            s_next.hold   = '0;
            s_next.toggle = 1'b0;
            s_next.active = 1'b0;
        end else if (!data_mode && !addr_mode) begin
            s_next.count  = '0;
            s_next.active = 1'b0;
        end else begin
            s_next.active = 1'b1;
            s_next.shift = nsh;
            if (s_reg.count == width - 1'b1) begin
                s_next.hold.is_addr = addr_mode;
                s_next.hold.payload = nsh >> (jril_pkg::PAY_W - int'(width));
                s_next.toggle       = ~s_reg.toggle;
                s_next.count        = '0;
            end else begin
                s_next.count = s_reg.count + 1'b1;
            end
        end
    end

    always_ff @(posedge link_clk_in) begin
        s_reg <= s_next;
    end

    assign hold_out   = s_reg.hold;
    assign toggle_out = s_reg.toggle;
    assign active_out = s_reg.active;

endmodule

// >>> verification/jril_host_model.sv
module jril_host_model (
    output logic                       link_clk_out,
    output logic [jril_pkg::CMD_W-1:0] cmd_out,
    output logic                       serial_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        link_clk_out = 1'b0;
        cmd_out      = 8'h00;
        serial_out   = 1'b0;
    end

    // ============================================================
    // Link clock pulses with no opcode loaded
    task automatic idle_clocks(input int n);
        #3;
        repeat (n) begin
            serial_out = ~serial_out;
            #40 link_clk_out = 1'b1;
            #40 link_clk_out = 1'b0;
        end
    endtask

    // ============================================================
    // Instruction update, clock held still
    // Opcode before shifting
    task automatic set_cmd(input logic [jril_pkg::CMD_W-1:0] c);
        #7 cmd_out = c;
    endtask

    // ============================================================
    // Serial shift, clock runs only inside the frame
    // Rising edge sampling
    task automatic send_bits(input logic [jril_pkg::PAY_W-1:0] v, input int nbits);
        #3;
        for (int i = 0; i < nbits; i++) begin
            serial_out = v[i];
            #40 link_clk_out = 1'b1;
            #40 link_clk_out = 1'b0;
        end
        // Released line must not keep showing the last bit
        serial_out = ~v[nbits-1];
    endtask
endmodule

// >>> verification/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int WR_W = jril_pkg::NUM_BLK + jril_pkg::ADDR_W + jril_pkg::DATA_W;

    logic                         clock_in    = 1'b0;
    logic                         sys_rst_in  = 1'b1;
    logic                         link_clk;
    logic [jril_pkg::CMD_W-1:0]   cmd;
    logic                         ser;
    logic [jril_pkg::NUM_BLK-1:0] ram_cs;
    logic [jril_pkg::ADDR_W-1:0]  ram_waddr;
    logic [jril_pkg::DATA_W-1:0]  ram_wdata;
    logic                         ram_wclk;
    logic                         loading;
    logic                         overrun;
    logic                         wclk_q      = 1'b0;
    logic [WR_W-1:0]              wr_q[$];
    int                           num_errors  = 0;
    int                           check_count = 0;

    always #5 clock_in = ~clock_in;

    jril_host_model jril_host_model_inst (
        .link_clk_out (link_clk),
        .cmd_out      (cmd),
        .serial_out   (ser)
    );

    jril_loader jril_loader_inst (
        .clock_in                  (clock_in),
        .sys_rst_in                (sys_rst_in),
        .bridge_data_reg_clock_in  (link_clk),
        .bridge_command_in         (cmd),
        .bridge_serial_data_out_in (ser),
        .ram_cs_out                (ram_cs),
        .ram_waddr_out             (ram_waddr),
        .ram_wdata_out             (ram_wdata),
        .ram_wclk_out              (ram_wclk),
        .loading_out               (loading),
        .overrun_out               (overrun)
    );

    // ============================================================
    // Helpers
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("Checks: %0d  Errors: %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Write strobe seen on its rising edge only
    always @(posedge clock_in) begin
        wclk_q <= ram_wclk;
        if (ram_wclk === 1'b1 && wclk_q === 1'b0) begin
            wr_q.push_back({ram_cs, ram_waddr, ram_wdata});
            check(32'(loading), 32'h1);
        end
    end

    task automatic expect_write(input logic [jril_pkg::NUM_BLK-1:0] cs,
                                input logic [jril_pkg::ADDR_W-1:0]  a,
                                input logic [jril_pkg::DATA_W-1:0]  d);
        logic [WR_W-1:0] got;
        got = '0;
        for (int i = 0; i < 300 && wr_q.size() == 0; i++) @(posedge clock_in);
        if (wr_q.size() != 0) begin
            got = wr_q.pop_front();
        end
        check(32'(got), 32'({cs, a, d}));
    endtask

    task automatic end_session();
        repeat (20) @(posedge clock_in);
        jril_host_model_inst.set_cmd(8'h00);
        jril_host_model_inst.idle_clocks(3);
        repeat (6) @(posedge clock_in);
        check(32'(loading), 32'h0);
        check(32'(wr_q.size()), 32'h0);
        check(32'(ram_cs), 32'h0);
    endtask

    // ============================================================
    // Scenarios
    task automatic test_reset();
        check(32'({ram_cs, ram_waddr, ram_wdata, ram_wclk}), 32'h0);
        check(32'({loading, overrun}), 32'h0);
    endtask

    task automatic test_burst();
        logic [jril_pkg::DATA_W-1:0] d;
        jril_host_model_inst.set_cmd(jril_pkg::CMD_LOAD_DATA);
        for (int i = 0; i < 10; i++) begin
            d = jril_pkg::DATA_W'(i * 9'h033 + 9'h155);
            jril_host_model_inst.send_bits(d, jril_pkg::DATA_W);
        end
        check(32'(loading), 32'h1);
        for (int i = 0; i < 10; i++) begin
            d = jril_pkg::DATA_W'(i * 9'h033 + 9'h155);
            expect_write(4'h1, jril_pkg::ADDR_W'(i), d);
        end
        check(32'(overrun), 32'h0);
        end_session();
    endtask

    task automatic test_wrap();
        jril_host_model_inst.set_cmd(jril_pkg::CMD_LOAD_ADDR);
        jril_host_model_inst.send_bits(9'h1FE, jril_pkg::ADDR_W);
        jril_host_model_inst.set_cmd(jril_pkg::CMD_LOAD_DATA);
        jril_host_model_inst.send_bits(9'h0AA, jril_pkg::DATA_W);
        jril_host_model_inst.send_bits(9'h155, jril_pkg::DATA_W);
        jril_host_model_inst.send_bits(9'h1FF, jril_pkg::DATA_W);
        expect_write(4'h1, 9'h1FE, 9'h0AA);
        expect_write(4'h1, 9'h1FF, 9'h155);
        expect_write(4'h2, 9'h000, 9'h1FF);
        end_session();
    endtask

    // Cut word must vanish; new session restarts at block 0
    task automatic test_partial();
        jril_host_model_inst.set_cmd(jril_pkg::CMD_LOAD_DATA);
        jril_host_model_inst.send_bits(9'h01F, 5);
        end_session();
        jril_host_model_inst.set_cmd(jril_pkg::CMD_LOAD_DATA);
        jril_host_model_inst.send_bits(9'h0C3, jril_pkg::DATA_W);
        expect_write(4'h1, 9'h000, 9'h0C3);
        end_session();
    endtask

    // ============================================================
    // Main sequence; reset spans link edges too
    initial begin
        jril_host_model_inst.idle_clocks(4);
        @(posedge clock_in);
        sys_rst_in <= 1'b0;
        jril_host_model_inst.idle_clocks(4);
        test_reset();
        test_burst();
        test_wrap();
        test_partial();
        summarize();
    end

    initial begin
        #200000;
        num_errors++;
        summarize();
    end
endmodule
